// ==== design/pfgs_defs.vh ====
// register map, field layouts, reset values and access codes of the pin function select block
`ifndef PFGS_DEFS_VH
`define PFGS_DEFS_VH

// system address window of the module
`define PFGS_BASE_ADDR 32'hd811_0000
`define PFGS_WIN_HI 31
`define PFGS_WIN_LO 16
`define PFGS_OFS_W 16

// register offsets inside the window
`define PFGS_OFS_CARD_EN 16'h0040
`define PFGS_OFS_VIDEO_EN 16'h0044
`define PFGS_OFS_CHG_STATUS 16'h0080
`define PFGS_OFS_CHG_COUNT 16'h0084
`define PFGS_OFS_TRIGGER 16'h0088
`define PFGS_OFS_LOCK 16'h008c
`define PFGS_OFS_PULL 16'h0090

// field layout
`define PFGS_CARD_W 8
`define PFGS_VOUT_MSB 31
`define PFGS_VOUT_LSB 8
`define PFGS_VOUT_W 24
`define PFGS_VIN_MSB 7
`define PFGS_VIN_LSB 0
`define PFGS_VIN_W 8
`define PFGS_CHG_W 2
`define PFGS_CHG_CARD_BIT 0
`define PFGS_CHG_VIDEO_BIT 1
`define PFGS_CNT_W 8
`define PFGS_TRIG_W 2
`define PFGS_TRIG_RESTORE_BIT 0
`define PFGS_TRIG_PULSE_BIT 1
`define PFGS_LOCK_W 1
`define PFGS_PULL_W 8

// reset values
`define PFGS_RST_CARD_EN 8'h00
`define PFGS_RST_VOUT_EN 24'h00_0000
`define PFGS_RST_VIN_EN 8'h00
`define PFGS_RST_CHG 2'h0
`define PFGS_RST_CNT 8'h00
`define PFGS_RST_TRIG 2'h0
`define PFGS_RST_LOCK 1'h0
`define PFGS_RST_PULL 8'h00

// field access kinds
`define PFGS_ACC_RW 3'h0
`define PFGS_ACC_WO 3'h1
`define PFGS_ACC_READ_WRITE_HW_UPDATE 3'h2
`define PFGS_ACC_WRITE_READ_ZERO 3'h3
`define PFGS_ACC_W1C 3'h4
`define PFGS_ACC_TRIG 3'h5

`endif

// ==== design/pfgs_field.v ====
// one register field whose software and hardware behaviour follows its access kind
`timescale 1ns/1ps
`include "pfgs_defs.vh"

module pfgs_field #(
  parameter WIDTH = 8,
  parameter [2:0] ACCESS = `PFGS_ACC_RW,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_wr_en,
  input wire [WIDTH-1:0] i_wr_data,
  input wire i_clr,
  input wire [WIDTH-1:0] i_hw_set,
  input wire i_hw_load,
  input wire [WIDTH-1:0] i_hw_data,
  output wire [WIDTH-1:0] o_value,
  output reg [WIDTH-1:0] o_rd_data,
  output wire [WIDTH-1:0] o_pulse
);

  reg [WIDTH-1:0] value_reg;
  reg [WIDTH-1:0] value_next;
  reg [WIDTH-1:0] pulse_reg;
  reg [WIDTH-1:0] pulse_next;

  assign o_value = value_reg;
  assign o_pulse = pulse_reg;

  always @* begin
    value_next = value_reg;
    pulse_next = {WIDTH{1'b0}};
    case (ACCESS)
      `PFGS_ACC_READ_WRITE_HW_UPDATE: begin
        // hardware update takes priority over a same-cycle software write
        if (i_hw_load) begin
          value_next = i_hw_data;
        end else if (i_wr_en) begin
          value_next = i_wr_data;
        end
      end
      `PFGS_ACC_W1C: begin
        // a hardware set in the clearing cycle survives
        value_next = (value_reg & ~(i_wr_en ? i_wr_data : {WIDTH{1'b0}})) | i_hw_set;
      end
      `PFGS_ACC_TRIG: begin
        // nothing is stored, the write only fires a one-cycle event
        value_next = {WIDTH{1'b0}};
        pulse_next = i_wr_en ? i_wr_data : {WIDTH{1'b0}};
      end
      default: begin
        if (i_wr_en) begin
          value_next = i_wr_data;
        end
      end
    endcase
    if (i_clr) begin
      value_next = RESET_VAL;
    end
  end

  always @* begin
    case (ACCESS)
      `PFGS_ACC_RW: o_rd_data = value_reg;
      `PFGS_ACC_READ_WRITE_HW_UPDATE: o_rd_data = value_reg;
      `PFGS_ACC_W1C: o_rd_data = value_reg;
      `PFGS_ACC_WO: o_rd_data = {WIDTH{1'b0}};
      `PFGS_ACC_WRITE_READ_ZERO: o_rd_data = {WIDTH{1'b0}};
      `PFGS_ACC_TRIG: o_rd_data = {WIDTH{1'b0}};
      default: o_rd_data = {WIDTH{1'b0}};
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      value_reg <= RESET_VAL;
      pulse_reg <= {WIDTH{1'b0}};
    end else begin
      value_reg <= value_next;
      pulse_reg <= pulse_next;
    end
  end

endmodule

// ==== design/pfgs_pin_select.v ====
// pin function select: card and video pin gpio enables with their register window
//
// Functional notes
// - module select goes high for every access inside the 64 KB window, else low.
// - register offsets are decoded relative to base address 0xD811_0000.
// - card enable bits 7..0 each release one card data line to gpio.
// - video enable bits 31:8 release the 24 video output pins to gpio.
// - video enable bits 7:0 release video input pins 7..0 to gpio.
// - write-only field takes writes, reads never return its stored value.
// - read-write-update field is software readable, writable, and hardware updated.
// - write-read-zero field takes writes and always reads back zero.
// - write-one-to-clear field reads normally; a one clears, a zero keeps.
// - trigger field reads zero; writing one fires its event, nothing stored.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "pfgs_defs.vh"

module pfgs_pin_select (
  input wire I_SYS_CLK,
  input wire I_NRST,
  input wire [31:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [31:0] O_RDATA,
  output reg O_GPIO_SEL,
  output wire [7:0] O_CARD_DATA_LINE_GPIO_EN,
  output wire [23:0] O_VIDEO_OUTPUT_PINS_GPIO_EN,
  output wire [7:0] O_VIDEO_INPUT_PINS_GPIO_EN,
  output wire [7:0] O_CARD_PULL_SEL,
  output wire O_SYNC_PULSE
);

  localparam [31:0] BASE_ADDR = `PFGS_BASE_ADDR;
  localparam [`PFGS_OFS_W-1:0] BASE_HI = BASE_ADDR[`PFGS_WIN_HI:`PFGS_WIN_LO];

  // reset release through two flops
  // so every register leaves reset on one clean edge
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;

  always @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // window decode
  wire win_hit;
  wire [`PFGS_OFS_W-1:0] ofs;
  wire acc_any;

  assign win_hit = (I_ADDR[`PFGS_WIN_HI:`PFGS_WIN_LO] == BASE_HI);
  assign ofs = I_ADDR[`PFGS_WIN_LO-1:0];
  assign acc_any = I_WR | I_RD;

  wire wr_hit;

  assign wr_hit = I_WR & win_hit;

  // lock word is write-only from software's view, so a stuck lock
  // cannot be discovered by reading; software must track what it wrote
  wire [`PFGS_LOCK_W-1:0] lock_val;
  wire [`PFGS_LOCK_W-1:0] lock_rd;

  // one strobe per register; a locked enable write is dropped without trace
  reg wr_card;
  reg wr_video;
  reg wr_chg;
  reg wr_cnt;
  reg wr_trig;
  reg wr_lock;
  reg wr_pull;

  always @* begin
    wr_card = 1'b0;
    wr_video = 1'b0;
    wr_chg = 1'b0;
    wr_cnt = 1'b0;
    wr_trig = 1'b0;
    wr_lock = 1'b0;
    wr_pull = 1'b0;
    if (wr_hit) begin
      case (ofs)
        `PFGS_OFS_CARD_EN: wr_card = ~lock_val[0];
        `PFGS_OFS_VIDEO_EN: wr_video = ~lock_val[0];
        `PFGS_OFS_CHG_STATUS: wr_chg = 1'b1;
        `PFGS_OFS_CHG_COUNT: wr_cnt = 1'b1;
        `PFGS_OFS_TRIGGER: wr_trig = 1'b1;
        `PFGS_OFS_LOCK: wr_lock = 1'b1;
        `PFGS_OFS_PULL: wr_pull = 1'b1;
        default: wr_pull = 1'b0;
      endcase
    end
  end

  // trigger field: restore pins and a one-cycle sync pulse
  wire [`PFGS_TRIG_W-1:0] trig_pulse;
  wire [`PFGS_TRIG_W-1:0] trig_rd;
  wire restore_all;

  assign restore_all = trig_pulse[`PFGS_TRIG_RESTORE_BIT];

  pfgs_field #(
    .WIDTH(`PFGS_TRIG_W),
    .ACCESS(`PFGS_ACC_TRIG),
    .RESET_VAL(`PFGS_RST_TRIG)
  ) u_trig (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_n),
    .i_wr_en(wr_trig),
    .i_wr_data(I_WDATA[`PFGS_TRIG_W-1:0]),
    .i_clr(1'b0),
    .i_hw_set({`PFGS_TRIG_W{1'b0}}),
    .i_hw_load(1'b0),
    .i_hw_data({`PFGS_TRIG_W{1'b0}}),
    .o_value(),
    .o_rd_data(trig_rd),
    .o_pulse(trig_pulse)
  );

  assign O_SYNC_PULSE = trig_pulse[`PFGS_TRIG_PULSE_BIT];

  pfgs_field #(
    .WIDTH(`PFGS_LOCK_W),
    .ACCESS(`PFGS_ACC_WRITE_READ_ZERO),
    .RESET_VAL(`PFGS_RST_LOCK)
  ) u_lock (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_n),
    .i_wr_en(wr_lock),
    .i_wr_data(I_WDATA[`PFGS_LOCK_W-1:0]),
    .i_clr(1'b0),
    .i_hw_set({`PFGS_LOCK_W{1'b0}}),
    .i_hw_load(1'b0),
    .i_hw_data({`PFGS_LOCK_W{1'b0}}),
    .o_value(lock_val),
    .o_rd_data(lock_rd),
    .o_pulse()
  );

  // card data line enables, bits above 7 are reserved and read zero
  wire [`PFGS_CARD_W-1:0] card_rd;

  pfgs_field #(
    .WIDTH(`PFGS_CARD_W),
    .ACCESS(`PFGS_ACC_RW),
    .RESET_VAL(`PFGS_RST_CARD_EN)
  ) u_card (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_n),
    .i_wr_en(wr_card),
    .i_wr_data(I_WDATA[`PFGS_CARD_W-1:0]),
    .i_clr(restore_all),
    .i_hw_set({`PFGS_CARD_W{1'b0}}),
    .i_hw_load(1'b0),
    .i_hw_data({`PFGS_CARD_W{1'b0}}),
    .o_value(O_CARD_DATA_LINE_GPIO_EN),
    .o_rd_data(card_rd),
    .o_pulse()
  );

  wire [`PFGS_VOUT_W-1:0] vout_rd;
  wire [`PFGS_VIN_W-1:0] vin_rd;

  pfgs_field #(
    .WIDTH(`PFGS_VOUT_W),
    .ACCESS(`PFGS_ACC_RW),
    .RESET_VAL(`PFGS_RST_VOUT_EN)
  ) u_vout (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_n),
    .i_wr_en(wr_video),
    .i_wr_data(I_WDATA[`PFGS_VOUT_MSB:`PFGS_VOUT_LSB]),
    .i_clr(restore_all),
    .i_hw_set({`PFGS_VOUT_W{1'b0}}),
    .i_hw_load(1'b0),
    .i_hw_data({`PFGS_VOUT_W{1'b0}}),
    .o_value(O_VIDEO_OUTPUT_PINS_GPIO_EN),
    .o_rd_data(vout_rd),
    .o_pulse()
  );

  pfgs_field #(
    .WIDTH(`PFGS_VIN_W),
    .ACCESS(`PFGS_ACC_RW),
    .RESET_VAL(`PFGS_RST_VIN_EN)
  ) u_vin (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_n),
    .i_wr_en(wr_video),
    .i_wr_data(I_WDATA[`PFGS_VIN_MSB:`PFGS_VIN_LSB]),
    .i_clr(restore_all),
    .i_hw_set({`PFGS_VIN_W{1'b0}}),
    .i_hw_load(1'b0),
    .i_hw_data({`PFGS_VIN_W{1'b0}}),
    .o_value(O_VIDEO_INPUT_PINS_GPIO_EN),
    .o_rd_data(vin_rd),
    .o_pulse()
  );

  // change detection against last cycle's enables; catches both software
  // writes and the restore event without decoding either
  reg [`PFGS_CARD_W-1:0] card_prev_reg;
  reg [`PFGS_VOUT_W+`PFGS_VIN_W-1:0] video_prev_reg;
  wire card_changed;
  wire video_changed;
  wire any_changed;
  reg [`PFGS_CHG_W-1:0] chg_set;

  always @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      card_prev_reg <= `PFGS_RST_CARD_EN;
      video_prev_reg <= {`PFGS_RST_VOUT_EN, `PFGS_RST_VIN_EN};
    end else begin
      card_prev_reg <= O_CARD_DATA_LINE_GPIO_EN;
      video_prev_reg <= {O_VIDEO_OUTPUT_PINS_GPIO_EN, O_VIDEO_INPUT_PINS_GPIO_EN};
    end
  end

  assign card_changed = (card_prev_reg != O_CARD_DATA_LINE_GPIO_EN);
  assign video_changed =
    (video_prev_reg != {O_VIDEO_OUTPUT_PINS_GPIO_EN, O_VIDEO_INPUT_PINS_GPIO_EN});
  assign any_changed = card_changed | video_changed;

  always @* begin
    chg_set = {`PFGS_CHG_W{1'b0}};
    chg_set[`PFGS_CHG_CARD_BIT] = card_changed;
    chg_set[`PFGS_CHG_VIDEO_BIT] = video_changed;
  end

  wire [`PFGS_CHG_W-1:0] chg_rd;

  pfgs_field #(
    .WIDTH(`PFGS_CHG_W),
    .ACCESS(`PFGS_ACC_W1C),
    .RESET_VAL(`PFGS_RST_CHG)
  ) u_chg (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_n),
    .i_wr_en(wr_chg),
    .i_wr_data(I_WDATA[`PFGS_CHG_W-1:0]),
    .i_clr(1'b0),
    .i_hw_set(chg_set),
    .i_hw_load(1'b0),
    .i_hw_data({`PFGS_CHG_W{1'b0}}),
    .o_value(),
    .o_rd_data(chg_rd),
    .o_pulse()
  );

  // change counter, wraps at its width
  wire [`PFGS_CNT_W-1:0] cnt_val;
  wire [`PFGS_CNT_W-1:0] cnt_rd;
  wire [`PFGS_CNT_W-1:0] cnt_inc;

  assign cnt_inc = cnt_val + {{(`PFGS_CNT_W-1){1'b0}}, 1'b1};

  pfgs_field #(
    .WIDTH(`PFGS_CNT_W),
    .ACCESS(`PFGS_ACC_READ_WRITE_HW_UPDATE),
    .RESET_VAL(`PFGS_RST_CNT)
  ) u_cnt (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_n),
    .i_wr_en(wr_cnt),
    .i_wr_data(I_WDATA[`PFGS_CNT_W-1:0]),
    .i_clr(1'b0),
    .i_hw_set({`PFGS_CNT_W{1'b0}}),
    .i_hw_load(any_changed),
    .i_hw_data(cnt_inc),
    .o_value(cnt_val),
    .o_rd_data(cnt_rd),
    .o_pulse()
  );

  wire [`PFGS_PULL_W-1:0] pull_rd;

  pfgs_field #(
    .WIDTH(`PFGS_PULL_W),
    .ACCESS(`PFGS_ACC_WO),
    .RESET_VAL(`PFGS_RST_PULL)
  ) u_pull (
    .i_clk(I_SYS_CLK),
    .i_rst_n(rst_n),
    .i_wr_en(wr_pull),
    .i_wr_data(I_WDATA[`PFGS_PULL_W-1:0]),
    .i_clr(1'b0),
    .i_hw_set({`PFGS_PULL_W{1'b0}}),
    .i_hw_load(1'b0),
    .i_hw_data({`PFGS_PULL_W{1'b0}}),
    .o_value(O_CARD_PULL_SEL),
    .o_rd_data(pull_rd),
    .o_pulse()
  );

  // read mux; unmapped offsets and misses outside the window read zero
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (ofs)
      `PFGS_OFS_CARD_EN: rd_mux = {{(32-`PFGS_CARD_W){1'b0}}, card_rd};
      `PFGS_OFS_VIDEO_EN: rd_mux = {vout_rd, vin_rd};
      `PFGS_OFS_CHG_STATUS: rd_mux = {{(32-`PFGS_CHG_W){1'b0}}, chg_rd};
      `PFGS_OFS_CHG_COUNT: rd_mux = {{(32-`PFGS_CNT_W){1'b0}}, cnt_rd};
      `PFGS_OFS_TRIGGER: rd_mux = {{(32-`PFGS_TRIG_W){1'b0}}, trig_rd};
      `PFGS_OFS_LOCK: rd_mux = {{(32-`PFGS_LOCK_W){1'b0}}, lock_rd};
      `PFGS_OFS_PULL: rd_mux = {{(32-`PFGS_PULL_W){1'b0}}, pull_rd};
      default: rd_mux = 32'h0000_0000;
    endcase
    if (!win_hit) begin
      rd_mux = 32'h0000_0000;
    end
  end

  // the select is registered so every output leaves a flop;
  // it therefore trails the access by one cycle
  always @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_GPIO_SEL <= 1'b0;
    end else begin
      O_GPIO_SEL <= acc_any & win_hit;
    end
  end

  // read data stand for one cycle only, so a stale word never lingers
  always @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_RDATA <= 32'h0000_0000;
    end else if (I_RD) begin
      O_RDATA <= rd_mux;
    end else begin
      O_RDATA <= 32'h0000_0000;
    end
  end

endmodule

// ==== verification/pfgs_pin_select_monitor.sv ====
// concurrent checks on the ports of the pin function select block
`timescale 1ns/1ps
module pfgs_monitor (
  input wire logic I_SYS_CLK,
  input wire logic I_NRST,
  input wire logic [31:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [31:0] O_RDATA,
  input wire logic O_GPIO_SEL,
  input wire logic [7:0] O_CARD_DATA_LINE_GPIO_EN,
  input wire logic [23:0] O_VIDEO_OUTPUT_PINS_GPIO_EN,
  input wire logic [7:0] O_VIDEO_INPUT_PINS_GPIO_EN,
  input wire logic [7:0] O_CARD_PULL_SEL,
  input wire logic O_SYNC_PULSE
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);
  wire logic win = I_ADDR[31:16] == 16'hd811;
  logic lock_q;
  // shadow of the lock bit, since it reads back as zero
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
    if (!I_NRST) lock_q <= 1'b0;
    else if (I_WR && I_ADDR == 32'hd811_008c) lock_q <= I_WDATA[0];
  sequence restore_s;
    I_WR && I_ADDR == 32'hd811_0088 && I_WDATA[0];
  endsequence
  sequence pulse_s;
    O_SYNC_PULSE ##1 !O_SYNC_PULSE;
  endsequence
  sel_in_window_a: assert property ((I_WR || I_RD) && win |=> O_GPIO_SEL)
    else $error("module select missing");
  sel_outside_a: assert property (!((I_WR || I_RD) && win) |=> !O_GPIO_SEL)
    else $error("module select without access");
  card_write_a: assert property (I_WR && I_ADDR == 32'hd811_0040 && !lock_q
    |=> O_CARD_DATA_LINE_GPIO_EN == $past(I_WDATA[7:0])) else $error("card enable wrong");
  video_write_a: assert property (I_WR && I_ADDR == 32'hd811_0044 && !lock_q
    |=> {O_VIDEO_OUTPUT_PINS_GPIO_EN, O_VIDEO_INPUT_PINS_GPIO_EN} == $past(I_WDATA))
    else $error("video enable wrong");
  card_read_a: assert property (I_RD && I_ADDR == 32'hd811_0040
    |=> O_RDATA == {24'h0, $past(O_CARD_DATA_LINE_GPIO_EN)}) else $error("card readback");
  read_idle_a: assert property (!I_RD |=> O_RDATA == 32'h0)
    else $error("read data outside read cycle");
  zero_read_a: assert property (I_RD && (!win || I_ADDR[15:0] == 16'h0088
    || I_ADDR[15:0] == 16'h008c || I_ADDR[15:0] == 16'h0090) |=> O_RDATA == 32'h0)
    else $error("hidden field read nonzero");
  pull_write_a: assert property (I_WR && I_ADDR == 32'hd811_0090
    |=> O_CARD_PULL_SEL == $past(I_WDATA[7:0])) else $error("pull select wrong");
  sync_pulse_a: assert property (I_WR && I_ADDR == 32'hd811_0088 && I_WDATA[1]
    |=> pulse_s) else $error("trigger pulse wrong");
  restore_all_a: assert property (restore_s |=> ##1 O_CARD_DATA_LINE_GPIO_EN == 8'h0
    && O_VIDEO_OUTPUT_PINS_GPIO_EN == 24'h0 && O_VIDEO_INPUT_PINS_GPIO_EN == 8'h0)
    else $error("restore left enables set");
endmodule
bind pfgs_pin_select pfgs_monitor mon_u (.I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .O_GPIO_SEL(O_GPIO_SEL), .O_CARD_DATA_LINE_GPIO_EN(O_CARD_DATA_LINE_GPIO_EN),
  .O_VIDEO_OUTPUT_PINS_GPIO_EN(O_VIDEO_OUTPUT_PINS_GPIO_EN),
  .O_VIDEO_INPUT_PINS_GPIO_EN(O_VIDEO_INPUT_PINS_GPIO_EN),
  .O_CARD_PULL_SEL(O_CARD_PULL_SEL), .O_SYNC_PULSE(O_SYNC_PULSE));

// ==== verification/pfgs_pin_select_tb.sv ====
// register level testbench of the pin function select block
`timescale 1ns/1ps
module pfgs_pin_select_tb;
  localparam logic [31:0] B = 32'hd811_0000;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  wire [31:0] rdata;
  wire sel;
  wire sync;
  wire [7:0] card;
  wire [7:0] vin;
  wire [7:0] pull;
  wire [23:0] vout;
  int fails = 0;
  int n_tests = 0;
  always #10 clk = ~clk;
  pfgs_pin_select dut_u (.I_SYS_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_GPIO_SEL(sel), .O_CARD_DATA_LINE_GPIO_EN(card),
    .O_VIDEO_OUTPUT_PINS_GPIO_EN(vout), .O_VIDEO_INPUT_PINS_GPIO_EN(vin),
    .O_CARD_PULL_SEL(pull), .O_SYNC_PULSE(sync));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one strobe cycle; leaves us 1 ns into the answer cycle
  task acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    chk(sel, a[31:16] == 16'hd811);
  endtask
  task rdc(input logic [31:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask
  task complete_run;
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({card, vin, pull}, 32'h0);
    chk(vout, 32'h0);
    rdc(B + 32'h40, 32'h0);
    rdc(B + 32'h44, 32'h0);
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, B + 32'h40, 32'hffff_ff00 | (32'h1 << i));
      chk(card, 32'h1 << i);
    end
    rdc(B + 32'h40, 32'h80);
    acc(1'b1, B + 32'h44, 32'h1234_5678);
    chk(vout, 32'h12_3456);
    chk(vin, 32'h78);
    rdc(B + 32'h44, 32'h1234_5678);
    // neighbours of the window must not reach the registers
    acc(1'b1, 32'hd812_0040, 32'h0);
    acc(1'b1, 32'hd810_0044, 32'h0);
    chk(card, 32'h80);
    chk(vin, 32'h78);
    rdc(32'hd812_0040, 32'h0);
    rdc(B + 32'h100, 32'h0);
    acc(1'b1, B + 32'h90, 32'h3c);
    chk(pull, 32'h3c);
    rdc(B + 32'h90, 32'h0);
    acc(1'b1, B + 32'h8c, 32'h1);
    rdc(B + 32'h8c, 32'h0);
    acc(1'b1, B + 32'h40, 32'h0);
    chk(card, 32'h80);
    acc(1'b1, B + 32'h8c, 32'h0);
    acc(1'b1, B + 32'h80, 32'h3);
    rdc(B + 32'h80, 32'h0);
    acc(1'b1, B + 32'h84, 32'h10);
    rdc(B + 32'h84, 32'h10);
    acc(1'b1, B + 32'h40, 32'h0f);
    chk(card, 32'h0f);
    rdc(B + 32'h84, 32'h11);
    rdc(B + 32'h80, 32'h1);
    acc(1'b1, B + 32'h80, 32'h0);
    rdc(B + 32'h80, 32'h1);
    acc(1'b1, B + 32'h80, 32'h1);
    rdc(B + 32'h80, 32'h0);
    acc(1'b1, B + 32'h88, 32'h2);
    chk(sync, 32'h1);
    @(posedge clk);
    #1;
    chk(sync, 32'h0);
    acc(1'b1, B + 32'h88, 32'h1);
    @(posedge clk);
    #1;
    chk({card, vin}, 32'h0);
    chk(vout, 32'h0);
    rdc(B + 32'h88, 32'h0);
    complete_run();
  end
endmodule
